//--- common/ptpo_pkg.sv
// Purpose: Shared constants for the dual pulse-train / modulation output block.
// Assumes: 20 MHz reference clock, 32-bit APB register access.
// Notes:   Every offset, field position, reset value and timing count lives here.
package ptpo_pkg;

   // Clock and time bases.
   localparam int CLK_PERIOD_NS = 50;
   localparam int US_TICK_NS    = 1000;
   localparam int US_TICK_CYC   = (US_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_TICK_US    = 1000;

   // Channel count and register map.
   localparam int          NUM_CH      = 2;
   localparam logic [7:0]  CH_STRIDE   = 8'h20;
   localparam logic [4:0]  OFF_CTRL    = 5'h00;
   localparam logic [4:0]  OFF_PERIOD  = 5'h04;
   localparam logic [4:0]  OFF_WIDTH   = 5'h08;
   localparam logic [4:0]  OFF_COUNT   = 5'h0c;
   localparam logic [4:0]  OFF_STATUS  = 5'h10;
   localparam logic [7:0]  ADDR_INVOKE = 8'h40;
   localparam logic [7:0]  ADDR_IRQ_ST = 8'h44;
   localparam logic [7:0]  ADDR_IRQ_CL = 8'h48;
   localparam logic [7:0]  ADDR_IRQ_EN = 8'h4c;

   // Control byte fields.
   localparam int CTL_UPD_PER = 0;
   localparam int CTL_UPD_WID = 1;
   localparam int CTL_UPD_CNT = 2;
   localparam int CTL_TB_MS   = 3;
   localparam int CTL_MODE    = 6;
   localparam int CTL_ENABLE  = 7;

   // Status byte fields.
   localparam int STS_OVF  = 6;
   localparam int STS_IDLE = 7;

   // Interrupt status layout: done events in the low bits, overflows above.
   localparam int IRQ_DONE_LSB = 0;
   localparam int IRQ_OVF_LSB  = 2;
   localparam int IRQ_W        = 4;

   // Reset values and limits.
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [15:0] PERIOD_RST = 16'h0000;
   localparam logic [15:0] WIDTH_RST  = 16'h0000;
   localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
   localparam logic [15:0] PERIOD_MIN = 16'h0002;

   // Running mode of one generator.
   typedef enum logic [1:0] {
      PTPO_IDLE,
      PTPO_TRAIN,
      PTPO_MOD
   } ptpo_mode_t;

endpackage

//--- rtl/ptpo_tick_gen.sv
// Purpose: Microsecond and millisecond tick enables from the reference clock.
// Assumes: Free-running dividers; ticks are one-cycle pulses.
// Notes:   The millisecond tick coincides with every thousandth microsecond tick.
module ptpo_tick_gen #(
   parameter int US_PER_MS = ptpo_pkg::MS_TICK_US
) (
   input  wire logic ref_clk,   // Reference clock.
   input  wire logic rst,       // Asynchronous reset, active high.
   output logic      us_tick,   // One-cycle pulse every microsecond.
   output logic      ms_tick    // One-cycle pulse every millisecond.
);
   import ptpo_pkg::*;

   logic [7:0]  us_cnt_q;
   logic [15:0] ms_cnt_q;
   wire         us_wrap = (us_cnt_q == 8'(US_TICK_CYC - 1));
   wire         ms_wrap = (ms_cnt_q == 16'(US_PER_MS - 1));

   // Cycle counter for the microsecond base, then microsecond counter for milliseconds.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         us_cnt_q <= 8'h00;
         ms_cnt_q <= 16'h0000;
      end
      else if (us_wrap)
      begin
         us_cnt_q <= 8'h00;
         ms_cnt_q <= ms_wrap ? 16'h0000 : ms_cnt_q + 16'h0001;
      end
      else
      begin
         us_cnt_q <= us_cnt_q + 8'h01;
      end
   end

   // Tick pulses are registered so they are clean enables downstream.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         us_tick <= 1'b0;
         ms_tick <= 1'b0;
      end
      else
      begin
         us_tick <= us_wrap;
         ms_tick <= us_wrap & ms_wrap;
      end
   end

endmodule

//--- rtl/ptpo_top.sv
// Purpose: Two independent pulse-train / pulse-width-modulation output generators.
// Assumes: APB slave with zero wait states; one 20 MHz clock; run_entry from same clock.
// Notes:   Software stages a control byte and values, then writes the invoke register.
// How it works
// - Two outputs, picked by index 0 or 1, each set independently as train or modulator.
// - An invoke write reads the staged control bits of the chosen output and starts, queues or stops it.
// - In train mode the high time is half the period.
// - A train emits exactly the programmed number of pulses, from one to the 32-bit maximum.
// - Train periods count microsecond or millisecond ticks.
// - An odd train period gives a high half one tick shorter than the low half.
// - In modulation mode the period repeats, high for the width at its start, low after.
// - Modulation period and width both use the selected time base.
// - The modulation width takes any value from 0 to 65,535 ticks.
// - A width equal to the period keeps the output on continuously.
// - A width of zero keeps the output off continuously.
// - A period below two ticks is replaced by two ticks.
// - Each output has an 8-bit control byte, 16-bit period and width, and a 32-bit count.
// - One train waits behind the active one; a third sets a sticky overflow flag.
// - A status flag shows whether the train is running or idle.
// - After reset all control bits, widths and counts are zero; staged periods are zero, active and waiting periods two ticks.
module ptpo_top #(
   parameter int US_PER_MS = ptpo_pkg::MS_TICK_US
) (
   input  wire logic        ref_clk,            // Reference clock, 20 MHz.
   input  wire logic        rst,                // Asynchronous reset, active high.
   input  wire logic        psel,               // APB select.
   input  wire logic        penable,            // APB access phase.
   input  wire logic        pwrite,             // APB direction, high for write.
   input  wire logic [7:0]  paddr,              // APB byte address.
   input  wire logic [31:0] pwdata,             // APB write data.
   output logic [31:0]      prdata,             // APB read data.
   output logic             pready,             // APB ready, always high.
   output logic             pslverr,            // APB error for unmapped addresses.
   input  wire logic        run_entry,          // Pulse on entry to run mode.
   output logic             pulse_output_zero,  // Pulse output of generator 0.
   output logic             pulse_output_one,   // Pulse output of generator 1.
   output logic             irq                 // Level interrupt.
);
   import ptpo_pkg::*;

   // Period clamp shared by invoke and queue paths.
   function automatic logic [15:0] clamp_period(input logic [15:0] p);
      clamp_period = (p < PERIOD_MIN) ? PERIOD_MIN : p;
   endfunction

   // Channel register decode helpers.
   function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [4:0] off);
      ch_hit = (a == (8'(ch) * CH_STRIDE) + {3'b000, off});
   endfunction

   logic us_tick;
   logic ms_tick;

   ptpo_tick_gen #(
      .US_PER_MS (US_PER_MS)
   ) u_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .us_tick (us_tick),
      .ms_tick (ms_tick)
   );

   // Bus phase decode.
   wire apb_setup = psel & ~penable;
   wire apb_wr    = psel & penable & pwrite;

   // Invoke write selects a generator by index.
   wire inv_hit = apb_wr & (paddr == ADDR_INVOKE);
   wire inv_idx = pwdata[0];

   wire [NUM_CH-1:0] ev_done;
   wire [NUM_CH-1:0] ev_ovf;
   wire [NUM_CH-1:0] ch_out;
   wire [31:0]       ch_rd [NUM_CH];
   wire [NUM_CH-1:0] ch_map;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++)
      begin : g_ch
         // Staged software values.
         logic [7:0]  ctl_q;
         logic [15:0] sper_q;
         logic [15:0] swid_q;
         logic [31:0] scnt_q;
         // Values loaded at invoke time.
         logic [15:0] lper_q, lper_d;
         logic [15:0] lwid_q, lwid_d;
         logic [31:0] lcnt_q, lcnt_d;
         // Running state.
         ptpo_mode_t  mode_q, mode_d;
         logic        tb_q, tb_d;
         logic [15:0] per_q, per_d;
         logic [15:0] wid_q, wid_d;
         logic [31:0] rem_q, rem_d;
         logic [15:0] ph_q, ph_d;
         // Waiting train specification.
         logic        qv_q, qv_d;
         logic        qtb_q, qtb_d;
         logic [15:0] qper_q, qper_d;
         logic [31:0] qcnt_q, qcnt_d;
         logic        ovf_q, ovf_d;
         logic        out_q;
         logic        done_p;
         logic        ovf_p;
         logic [15:0] hi_d;

         wire inv     = inv_hit & (inv_idx == 1'(gi));
         wire wr_ctl  = apb_wr & ch_hit(paddr, gi, OFF_CTRL);
         wire wr_per  = apb_wr & ch_hit(paddr, gi, OFF_PERIOD);
         wire wr_wid  = apb_wr & ch_hit(paddr, gi, OFF_WIDTH);
         wire wr_cnt  = apb_wr & ch_hit(paddr, gi, OFF_COUNT);
         wire wr_sts  = apb_wr & ch_hit(paddr, gi, OFF_STATUS);
         wire tick    = tb_q ? ms_tick : us_tick;
         wire end_per = (ph_q == per_q - 16'h0001);
         wire busy    = (mode_q == PTPO_TRAIN);
         wire [15:0] nper = ctl_q[CTL_UPD_PER] ? sper_q : lper_q;
         wire [15:0] nwid = ctl_q[CTL_UPD_WID] ? swid_q : lwid_q;
         wire [31:0] ncnt = ctl_q[CTL_UPD_CNT] ? scnt_q : lcnt_q;

         // Software staging registers, all zero after reset.
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
            begin
               ctl_q  <= CTRL_RST;
               sper_q <= PERIOD_RST;
               swid_q <= WIDTH_RST;
               scnt_q <= COUNT_RST;
            end
            else
            begin
               if (wr_ctl) ctl_q <= pwdata[7:0];
               if (wr_per) sper_q <= pwdata[15:0];
               if (wr_wid) swid_q <= pwdata[15:0];
               if (wr_cnt) scnt_q <= pwdata;
            end
         end

         // Next state of the generator: invoke, then tick stepping, then flag upkeep.
         always_comb
         begin
            lper_d = lper_q;
            lwid_d = lwid_q;
            lcnt_d = lcnt_q;
            mode_d = mode_q;
            tb_d   = tb_q;
            per_d  = per_q;
            wid_d  = wid_q;
            rem_d  = rem_q;
            ph_d   = ph_q;
            qv_d   = qv_q;
            qtb_d  = qtb_q;
            qper_d = qper_q;
            qcnt_d = qcnt_q;
            ovf_d  = ovf_q;
            done_p = 1'b0;
            ovf_p  = 1'b0;
            if (inv)
            begin
               lper_d = nper;
               lwid_d = nwid;
               lcnt_d = ncnt;
               if (!ctl_q[CTL_ENABLE])
               begin
                  mode_d = PTPO_IDLE;
                  qv_d   = 1'b0;
                  done_p = busy;
               end
               else if (ctl_q[CTL_MODE])
               begin
                  // Modulation restarts its cycle at once with the new values.
                  mode_d = PTPO_MOD;
                  tb_d   = ctl_q[CTL_TB_MS];
                  per_d  = clamp_period(nper);
                  wid_d  = nwid;
                  ph_d   = 16'h0000;
                  qv_d   = 1'b0;
               end
               else if (busy)
               begin
                  if (!qv_q)
                  begin
                     qv_d   = 1'b1;
                     qtb_d  = ctl_q[CTL_TB_MS];
                     qper_d = clamp_period(nper);
                     qcnt_d = ncnt;
                  end
                  else
                  begin
                     ovf_p = 1'b1;
                  end
               end
               else if (ncnt != 32'h0000_0000)
               begin
                  mode_d = PTPO_TRAIN;
                  tb_d   = ctl_q[CTL_TB_MS];
                  per_d  = clamp_period(nper);
                  rem_d  = ncnt;
                  ph_d   = 16'h0000;
               end
               else
               begin
                  mode_d = PTPO_IDLE;
               end
            end
            else if (tick && mode_q != PTPO_IDLE)
            begin
               if (!end_per)
               begin
                  ph_d = ph_q + 16'h0001;
               end
               else
               begin
                  ph_d = 16'h0000;
                  if (busy)
                  begin
                     if (rem_q != 32'h0000_0001)
                     begin
                        rem_d = rem_q - 32'h0000_0001;
                     end
                     else if (qv_q)
                     begin
                        // Chain the waiting train with no gap.
                        qv_d  = 1'b0;
                        tb_d  = qtb_q;
                        per_d = qper_q;
                        rem_d = qcnt_q;
                     end
                     else
                     begin
                        mode_d = PTPO_IDLE;
                        done_p = 1'b1;
                     end
                  end
               end
            end
            // Overflow clears on run entry or a software status write with the overflow bit zero, but a new overflow wins.
            if (run_entry || (wr_sts && !pwdata[STS_OVF]))
            begin
               ovf_d = 1'b0;
            end
            if (ovf_p)
            begin
               ovf_d = 1'b1;
            end
            // High time: half the period for trains, the width for modulation.
            if (mode_d == PTPO_MOD)
            begin
               hi_d = wid_d;
            end
            else
            begin
               hi_d = {1'b0, per_d[15:1]};
            end
         end

         // Generator state registers.
         always_ff @(posedge ref_clk or posedge rst)
         begin
            if (rst)
            begin
               lper_q <= PERIOD_RST;
               lwid_q <= WIDTH_RST;
               lcnt_q <= COUNT_RST;
               mode_q <= PTPO_IDLE;
               tb_q   <= 1'b0;
               per_q  <= PERIOD_MIN;
               wid_q  <= WIDTH_RST;
               rem_q  <= COUNT_RST;
               ph_q   <= 16'h0000;
               qv_q   <= 1'b0;
               qtb_q  <= 1'b0;
               qper_q <= PERIOD_MIN;
               qcnt_q <= COUNT_RST;
               ovf_q  <= 1'b0;
               out_q  <= 1'b0;
            end
            else
            begin
               lper_q <= lper_d;
               lwid_q <= lwid_d;
               lcnt_q <= lcnt_d;
               mode_q <= mode_d;
               tb_q   <= tb_d;
               per_q  <= per_d;
               wid_q  <= wid_d;
               rem_q  <= rem_d;
               ph_q   <= ph_d;
               qv_q   <= qv_d;
               qtb_q  <= qtb_d;
               qper_q <= qper_d;
               qcnt_q <= qcnt_d;
               ovf_q  <= ovf_d;
               out_q  <= (mode_d != PTPO_IDLE) && (ph_d < hi_d);
            end
         end

         // Export per-channel results.
         assign ev_done[gi] = done_p;
         assign ev_ovf[gi]  = ovf_p;
         assign ch_out[gi]  = out_q;
         assign ch_map[gi]  = ch_hit(paddr, gi, OFF_CTRL) | ch_hit(paddr, gi, OFF_PERIOD)
                            | ch_hit(paddr, gi, OFF_WIDTH) | ch_hit(paddr, gi, OFF_COUNT)
                            | ch_hit(paddr, gi, OFF_STATUS);
         assign ch_rd[gi]   = ch_hit(paddr, gi, OFF_CTRL)   ? {24'h000000, ctl_q} :
                              ch_hit(paddr, gi, OFF_PERIOD) ? {16'h0000, sper_q} :
                              ch_hit(paddr, gi, OFF_WIDTH)  ? {16'h0000, swid_q} :
                              ch_hit(paddr, gi, OFF_COUNT)  ? scnt_q :
                              ch_hit(paddr, gi, OFF_STATUS) ?
                                 {24'h000000, ~busy, ovf_q, 6'h00} : 32'h0000_0000;
      end
   endgenerate

   assign pulse_output_zero = ch_out[0];
   assign pulse_output_one  = ch_out[1];

   // Interrupt status: sticky events, write-one-to-clear, set wins over clear.
   logic [IRQ_W-1:0] irq_st_q;
   logic [IRQ_W-1:0] irq_en_q;
   wire  [IRQ_W-1:0] irq_set = {ev_ovf, ev_done};
   wire  [IRQ_W-1:0] irq_clr = (apb_wr && paddr == ADDR_IRQ_CL) ? pwdata[IRQ_W-1:0]
                                                                 : {IRQ_W{1'b0}};

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_st_q <= {IRQ_W{1'b0}};
         irq_en_q <= {IRQ_W{1'b0}};
      end
      else
      begin
         irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
         if (apb_wr && paddr == ADDR_IRQ_EN) irq_en_q <= pwdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_st_q & irq_en_q);

   // Read decode and map check.
   wire glob_map = (paddr == ADDR_INVOKE) | (paddr == ADDR_IRQ_ST)
                 | (paddr == ADDR_IRQ_CL) | (paddr == ADDR_IRQ_EN);
   wire mapped   = glob_map | (|ch_map);
   wire [31:0] rd_mux = (paddr == ADDR_IRQ_ST) ? {28'h0000000, irq_st_q} :
                        (paddr == ADDR_IRQ_EN) ? {28'h0000000, irq_en_q} :
                        ch_rd[0] | ch_rd[1];

   // Read data is captured in the setup cycle and stands through the access.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (apb_setup)
      begin
         prdata <= (!pwrite && mapped) ? rd_mux : 32'h0000_0000;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

endmodule

//--- tb/ptpo_load_model.sv
// Purpose: Load on one pulse output that times its high and low phases.
// Assumes: Output sampled on the reference clock.
// Notes:   Lengths are of the last completed phase, in clock cycles.
module ptpo_load_model (
   input wire logic ref_clk, // Clock.
   input wire logic level,   // Output under test.
   output int       rises,   // Rising edges seen.
   output int       hi_len,  // Last high phase length.
   output int       lo_len   // Last low phase length.
);
   timeunit 1ns;
   timeprecision 1ns;
   int   run = 0;
   int   nrise = 0;
   logic prev = 1'b0;

   // Each level change closes the phase that ran before it.
   always @(posedge ref_clk)
   begin
      if (level !== prev)
      begin
         if (level === 1'b1)
         begin
            lo_len <= run;
            nrise  <= nrise + 1;
         end
         else
            hi_len <= run;
         run <= 1;
      end
      else
         run <= run + 1;
      prev <= level;
   end
   assign rises = nrise;
endmodule

//--- tb/ptpo_props.sv
// Purpose: Port-level checks on the dual pulse output block.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Channel 0 control byte is shadowed here from APB writes.
module ptpo_props #(
   parameter int US_PER_MS = ptpo_pkg::MS_TICK_US
) (
   input wire logic        ref_clk,           // Clock.
   input wire logic        rst,               // Reset.
   input wire logic        psel,              // APB select.
   input wire logic        penable,           // APB access phase.
   input wire logic        pwrite,            // APB direction.
   input wire logic [7:0]  paddr,             // APB address.
   input wire logic [31:0] pwdata,            // APB write data.
   input wire logic [31:0] prdata,            // APB read data.
   input wire logic        pready,            // APB ready.
   input wire logic        pslverr,           // APB error.
   input wire logic        run_entry,         // Run mode entry.
   input wire logic        pulse_output_zero, // Output 0.
   input wire logic        pulse_output_one,  // Output 1.
   input wire logic        irq                // Interrupt.
);
   timeunit 1ns;
   timeprecision 1ns;
   import ptpo_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Access decode; addresses from 0x50 up hold no register.
   wire       acc  = psel && penable;
   wire       bad  = paddr >= 8'h50;
   wire       inv0 = acc && pwrite && paddr == ADDR_INVOKE && !pwdata[0];
   logic [7:0] ctl0_q;
   wire [7:0] ctl0_d = (acc && pwrite && paddr == {3'h0, OFF_CTRL}) ? pwdata[7:0] : ctl0_q;

   // Shadow of the staged control byte, so invoke effects can be predicted.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ctl0_q <= CTRL_RST;
      else
         ctl0_q <= ctl0_d;
   end

   a_ready_high: assert property (pready) else $error("pready low");
   a_err_unmapped: assert property (acc && bad |-> pslverr)
      else $error("no error on unmapped access");
   a_err_access: assert property (pslverr |-> acc) else $error("error outside access");
   a_rd_unmapped: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_wo_reads_zero: assert property (acc && !pwrite &&
      (paddr == ADDR_INVOKE || paddr == ADDR_IRQ_CL) |-> prdata == 32'h0)
      else $error("write-only register read not zero");
   a_irq_masked: assert property (acc && pwrite && paddr == ADDR_IRQ_EN &&
      pwdata[3:0] == 4'h0 |=> !irq) else $error("irq high while masked");
   a_disable_low: assert property (inv0 && !ctl0_q[CTL_ENABLE]
      |=> !pulse_output_zero [*2]) else $error("output not low after disable");
   a_reset_quiet: assert property ($fell(rst) |-> !pulse_output_zero &&
      !pulse_output_one && prdata == 32'h0) else $error("outputs busy after reset");
endmodule

bind ptpo_top ptpo_props #(.US_PER_MS(US_PER_MS)) u_props (.ref_clk(ref_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_entry(run_entry),
   .pulse_output_zero(pulse_output_zero), .pulse_output_one(pulse_output_one), .irq(irq));

//--- tb/tb.sv
// Purpose: Register-level tests of the dual pulse output block.
// Assumes: Short millisecond divider for run time.
// Notes:   Phase lengths are measured by the load models.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import ptpo_pkg::*;
   localparam int UPM = 4;
   localparam int TK  = US_TICK_CYC;
   logic ref_clk, rst, psel, penable, pwrite, run_entry;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, out0, out1, irq, er;
   int errors = 0, comparisons = 0, n, m, r0, h0, l0, r1, h1, l1;

   ptpo_top #(.US_PER_MS(UPM)) dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .run_entry(run_entry),
      .pulse_output_zero(out0), .pulse_output_one(out1), .irq(irq));
   ptpo_load_model u_ld0 (.ref_clk(ref_clk), .level(out0), .rises(r0), .hi_len(h0),
      .lo_len(l0));
   ptpo_load_model u_ld1 (.ref_clk(ref_clk), .level(out1), .rises(r1), .hi_len(h1),
      .lo_len(l1));

   // Clock at 20 MHz.
   always #25 ref_clk = ~ref_clk;

   function automatic logic [7:0] ra(input int ch, input logic [4:0] off);
      return ch[0] ? CH_STRIDE + {3'h0, off} : {3'h0, off};
   endfunction

   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask

   // One APB transfer; the request stands until pready is sampled high.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rc(input string s, input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(s, rd, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
   endtask

   // Polls the idle flag of one channel, with a bounded number of reads.
   task automatic wait_idle(input int ch);
      for (int i = 0; i < 400; i++)
      begin
         xfer(1'b0, ra(ch, OFF_STATUS), 32'h0);
         if (rd[STS_IDLE] === 1'b1)
            break;
      end
      chk("idle", {31'h0, rd[STS_IDLE]}, 32'h1);
   endtask

   task automatic stage(input int ch, input logic [7:0] c, input logic [31:0] p,
                        input logic [31:0] w, input logic [31:0] k);
      wr(ra(ch, OFF_CTRL), {24'h0, c});
      wr(ra(ch, OFF_PERIOD), p);
      wr(ra(ch, OFF_WIDTH), w);
      wr(ra(ch, OFF_COUNT), k);
      wr(ADDR_INVOKE, ch);
   endtask

   task automatic give_verdict;
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog against a hung handshake or a train that never ends.
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      errors++;
      give_verdict();
   end

   // Main sequence.
   initial
   begin
      ref_clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h0; pwdata = 32'h0; run_entry = 1'b0;
      cyc(10);
      rst <= 1'b0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         rc("ctrl", ra(c, OFF_CTRL), 32'h0);
         rc("period", ra(c, OFF_PERIOD), 32'h0);
         rc("width", ra(c, OFF_WIDTH), 32'h0);
         rc("count", ra(c, OFF_COUNT), 32'h0);
         rc("status", ra(c, OFF_STATUS), 32'h80);
      end
      wr(ra(0, OFF_CTRL), 32'hffff_ffff);
      wr(ra(0, OFF_PERIOD), 32'hffff_ffff);
      wr(ra(0, OFF_WIDTH), 32'hffff_ffff);
      wr(ra(0, OFF_COUNT), 32'hffff_ffff);
      rc("ctrl w", ra(0, OFF_CTRL), 32'hff);
      rc("period w", ra(0, OFF_PERIOD), 32'hffff);
      rc("width w", ra(0, OFF_WIDTH), 32'hffff);
      rc("count w", ra(0, OFF_COUNT), 32'hffff_ffff);
      rc("unmapped", 8'h50, 32'h0);
      chk("unmapped err", {31'h0, er}, 32'h1);
      // Odd-period train of three pulses on output 0.
      n = r0;
      stage(0, 8'h85, 5, 0, 3);
      rc("busy", ra(0, OFF_STATUS), 32'h00);
      wait_idle(0);
      chk("pulses", r0 - n, 3);
      chk("high", h0, 2 * TK);
      chk("low", l0, 3 * TK);
      rc("done irq", ADDR_IRQ_ST, 32'h1);
      wr(ADDR_IRQ_CL, 32'hf);
      rc("irq clr", ADDR_IRQ_ST, 32'h0);
      // Period below two ticks on output 1; output 0 must not move.
      n = r1;
      m = r0;
      stage(1, 8'h85, 1, 0, 2);
      wait_idle(1);
      chk("pulses1", r1 - n, 2);
      chk("high1", h1, TK);
      chk("low1", l1, TK);
      chk("quiet0", r0 - m, 0);
      // Modulation: width change only, then full and empty duty.
      stage(0, 8'hc3, 4, 1, 0);
      cyc(300);
      chk("pwm high", h0, TK);
      chk("pwm low", l0, 3 * TK);
      wr(ra(0, OFF_PERIOD), 9);
      stage(0, 8'hc2, 9, 3, 0);
      cyc(300);
      chk("kept high", h0, 3 * TK);
      chk("kept low", l0, TK);
      for (int w = 0; w < 2; w++)
      begin
         stage(0, 8'hc2, 0, w ? 4 : 0, 0);
         cyc(5);
         n = r0;
         cyc(200);
         chk("steady", {31'h0, out0}, w);
         chk("no edge", r0 - n, 0);
      end
      stage(0, 8'hcb, 3, 1, 0);
      cyc(800);
      chk("ms high", h0, UPM * TK);
      chk("ms low", l0, 2 * UPM * TK);
      stage(0, 8'h00, 0, 0, 0);
      cyc(2);
      chk("off", {31'h0, out0}, 0);
      // Queue of one behind the active train, then overflow.
      for (int i = 0; i < 3; i++)
         stage(0, 8'h85, 2, 0, 10);
      rc("ovf", ra(0, OFF_STATUS), 32'h40);
      // The done event of output 1 is still pending beside the new overflow.
      rc("ovf irq", ADDR_IRQ_ST, 32'h6);
      wr(ADDR_IRQ_EN, 32'h4);
      cyc(1);
      chk("irq on", {31'h0, irq}, 1);
      wr(ADDR_IRQ_EN, 32'h0);
      cyc(1);
      chk("irq mask", {31'h0, irq}, 0);
      wr(ra(0, OFF_STATUS), 32'h0);
      rc("ovf sw", ra(0, OFF_STATUS), 32'h00);
      wr(ADDR_INVOKE, 32'h0);
      rc("ovf again", ra(0, OFF_STATUS), 32'h40);
      run_entry <= 1'b1;
      cyc(1);
      run_entry <= 1'b0;
      rc("ovf run", ra(0, OFF_STATUS), 32'h00);
      stage(0, 8'h00, 0, 0, 0);
      wait_idle(0);
      wr(ADDR_IRQ_CL, 32'hf);
      rc("irq end", ADDR_IRQ_ST, 32'h0);
      give_verdict();
   end
endmodule
